/* File: rtl/cwd_pkg.sv */
package cwd_pkg;

   // ----------------------------------------------------------------
   // Configuration space map
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 14;          // Program address
   localparam int          WORD_W        = 16;          // Config word
   localparam logic [13:0] CFG_SPACE_LO  = 14'h2000;    // Region start
   localparam logic [13:0] CFG_SPACE_HI  = 14'h3FFF;    // Region end
   localparam logic [13:0] CFG_WORD_ADDR = 14'h2007;    // Word one home
   localparam int          STORE_DEPTH   = 8;           // 2000h..2007h
   localparam int          STORE_IDX_W   = 3;           // Index width
   localparam logic [13:0] STORE_TOP     = 14'h2007;    // Last stored
   localparam logic [15:0] CFG_UNIMP_MASK = 16'hC000;   // Bits 15..14
   localparam logic [15:0] CFG_ERASED    = 16'hFFFF;    // Unprogrammed
   localparam logic [15:0] RD_NONE       = 16'h0000;    // Outside store

   // ----------------------------------------------------------------
   // Field positions inside configuration_word_one
   // ----------------------------------------------------------------
   localparam int BIT_DEBUG   = 13;  // Debugger pin takeover, low active
   localparam int BIT_LVP     = 12;  // low_volt_prog_enable
   localparam int BIT_FCM     = 11;  // clock_fail_monitor_enable
   localparam int BIT_SWO     = 10;  // clock_switchover_enable
   localparam int BIT_BOR_HI  = 9;   // brownout_policy msb
   localparam int BIT_BOR_LO  = 8;   // brownout_policy lsb
   localparam int BIT_CPD     = 7;   // data_mem_protect_n
   localparam int BIT_CP      = 6;   // program_mem_protect_n
   localparam int BIT_MASTER_CLEAR_PIN_SELECT   = 5;   // master_clear_pin_select
   localparam int BIT_POWER_UP_DELAY_ENABLE_N   = 4;   // power_up_delay_enable_n
   localparam int BIT_WATCHDOG_FORCE_ENABLE    = 3;   // watchdog_force_enable

   // Brown-out policy codes
   typedef enum logic [1:0] {
      BOR_OFF    = 2'h0,             // Never armed
      BOR_SOFT   = 2'h1,             // Software bit decides
      BOR_AWAKE  = 2'h2,             // Armed except while asleep
      BOR_ALWAYS = 2'h3              // Always armed
   } cwd_bor_t;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_FREQ_KHZ   = 250_000;  // ref_clk rate
   localparam int unsigned POWER_UP_DELAY_TIMER_DELAY_MS  = 64;       // Nominal delay
   localparam int unsigned POWER_UP_DELAY_TIMER_CYCLES    = POWER_UP_DELAY_TIMER_DELAY_MS * CLK_FREQ_KHZ;
   localparam int          POWER_UP_DELAY_TIMER_W         = 24;       // Counter width
   localparam int unsigned OSC_SETTLE_TICKS = 1024;   // Oscillator ticks
   localparam int          OST_W          = 11;       // Counter width

   // ----------------------------------------------------------------
   // Reset and power sequencer states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_HOLD  = 5'b0_0001,          // Held in reset, word latched
      ST_POWER_UP_DELAY_TIMER  = 5'b0_0010,          // Power-up delay running
      ST_OST   = 5'b0_0100,          // Oscillator settling
      ST_RUN   = 5'b0_1000,          // Normal operation
      ST_SLEEP = 5'b1_0000           // Low-power sleep
   } cwd_state_e_t;

   // Decoded static controls
   typedef struct packed {
      logic debugPinsOwned;          // Clock/data pins given to debugger
      logic lowVoltProgEnable;       // Mode pin has programming function
      logic clockFailMonitorEnable;  // Clock failure monitor on
      logic clockSwitchoverEnable;   // Internal/external switchover on
      logic brownoutArmed;           // Brown-out may reset now
      logic dataMemProtect;          // Data memory read-out blocked
      logic programMemProtect;       // Program memory read-out blocked
      logic masterClearActive;       // Pin works as master clear
      logic watchdogEnable;          // Watchdog running
   } cwd_ctrl_t;

   // Programming port request
   typedef struct packed {
      logic [13:0] addr;             // Word address
      logic [15:0] wrData;           // Word to program
      logic        wrEn;             // Write strobe
      logic        rdEn;             // Read strobe
   } cwd_prog_req_t;

endpackage : cwd_pkg

/* File: rtl/cwd_delay_timer.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// One-shot down counter; done stays high until the next start
// ----------------------------------------------------------------
module cwd_delay_timer #(
   parameter int                 WIDTH = 8,
   parameter logic [WIDTH-1:0]   LOAD  = '1
) (
   input  wire logic ref_clk,
   input  wire logic rst_b,
   input  wire logic start,
   input  wire logic tick,
   output      logic done
);

   typedef struct packed {
      logic [WIDTH-1:0] cnt;         // Remaining ticks
      logic             busy;        // Counting
      logic             done;        // Expired since last start
   } cwd_tmr_t;

   cwd_tmr_t s_r;                    // Registered state
   cwd_tmr_t s_nxt;                  // Next state

   // Count ticks after start; restart clears done
   always_comb begin
      s_nxt = s_r;
      if (start) begin
         s_nxt.cnt  = LOAD;
         s_nxt.busy = 1'b1;
         s_nxt.done = 1'b0;
      end else if (s_r.busy && tick) begin
         s_nxt.cnt = s_r.cnt - WIDTH'(1);
         if (s_r.cnt <= WIDTH'(1)) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign done = s_r.done;

endmodule : cwd_delay_timer

/* File: rtl/cwd_cfg_store.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Configuration words 2000h..2007h; erased to all ones by rst_b
// ----------------------------------------------------------------
module cwd_cfg_store (
   input  wire logic                            ref_clk,
   input  wire logic                            rst_b,
   input  wire logic                            wrEn,
   input  wire logic [cwd_pkg::STORE_IDX_W-1:0] idx,
   input  wire logic [cwd_pkg::WORD_W-1:0]      wrData,
   output      logic [cwd_pkg::WORD_W-1:0]      rdData,
   output      logic [cwd_pkg::WORD_W-1:0]      cfgWord
);

   typedef struct packed {
      logic [cwd_pkg::STORE_DEPTH-1:0][cwd_pkg::WORD_W-1:0] mem; // Words
      logic [cwd_pkg::WORD_W-1:0] rdData;                       // Read reg
      logic [cwd_pkg::WORD_W-1:0] cfgWord;                      // Word one
   } cwd_store_t;

   localparam logic [cwd_pkg::STORE_IDX_W-1:0] CFG_IDX =
      cwd_pkg::CFG_WORD_ADDR[cwd_pkg::STORE_IDX_W-1:0];

   cwd_store_t s_r;                  // Registered state
   cwd_store_t s_nxt;                // Next state

   // Write and registered read; a read in the write cycle sees the old word; unimplemented bits forced to ones
   always_comb begin
      s_nxt = s_r;
      if (wrEn) begin
         s_nxt.mem[idx] = wrData;
      end
      s_nxt.rdData  = s_r.mem[idx] | cwd_pkg::CFG_UNIMP_MASK;
      s_nxt.cfgWord = s_r.mem[CFG_IDX] | cwd_pkg::CFG_UNIMP_MASK;
   end

   // Non-volatile contents modelled as erased after power-on
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s_r <= {cwd_pkg::STORE_DEPTH+2{cwd_pkg::CFG_ERASED}};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdData  = s_r.rdData;
   assign cfgWord = s_r.cfgWord;

endmodule : cwd_cfg_store

/* File: rtl/cwd_config_word_decode.sv */
`timescale 1ns/1ns
//
// Function
// - Power-up holds reset for 64 ms delay
// - Brown-out reset may extend through delay timer
// - Hold reset until crystal oscillator is stable
// - Leave sleep on reset, watchdog or interrupt
// - Programmed bit reads 0, unprogrammed reads 1
// - Word one lives at address 2007h
// - Config region reachable only in programming mode
// - Bits 15 and 14 always read 1; region reads past 2007h return 0000h
// - Bit 13 low gives pins to debugger
// - Bit 12 high enables low-voltage programming pin
// - Bit 11 high enables clock failure monitor
// - Bit 10 high enables clock switchover
// - Bits 9-8 choose brown-out reset policy
// - Bit 7 low protects data memory
// - Bit 6 low protects program memory
// - Bit 5 high makes pin master clear
// - Bit 4 low enables power-up delay
// - Bit 3 high forces watchdog on
//
module cwd_config_word_decode #(
   parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = cwd_pkg::POWER_UP_DELAY_TIMER_CYCLES
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_b,
   input  wire logic                  masterClearPin_b,
   input  wire logic                  brownoutDetect,
   input  wire logic                  wdtTimeout,
   input  wire logic                  irqPending,
   input  wire logic                  sleepReq,
   input  wire logic                  oscCrystalMode,
   input  wire logic                  oscTick,
   input  wire logic                  softwareBrownoutEnable,
   input  wire logic                  watchdogSoftEnable,
   input  wire logic                  hvProgEntry,
   input  wire logic                  progModePin,
   input  wire cwd_pkg::cwd_prog_req_t progReq,
   output      cwd_pkg::cwd_ctrl_t    ctrl,
   output      logic                  deviceReset,
   output      logic                  sleeping,
   output      logic                  wakePulse,
   output      logic                  progModeActive,
   output      logic [15:0]           progRdData,
   output      logic                  progRdValid
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      cwd_pkg::cwd_state_e_t state;   // Sequencer state
      logic [15:0]          cfgWord;  // Latched configuration word
      cwd_pkg::cwd_ctrl_t   ctrl;     // Decoded controls
      logic                 needPwrt; // Reset cause wants the delay
      logic                 pwrtStart; // Delay timer start pulse
      logic                 ostStart; // Settle timer start pulse
      logic                 deviceReset; // Core held in reset
      logic                 sleeping; // In sleep
      logic                 wakePulse; // Sleep exit, one cycle
      logic                 progMode; // Programming mode active
      logic                 rdPend;   // Store read in flight
      logic                 rdHit;    // Pending read inside store
      logic [15:0]          rdData;   // Read answer
      logic                 rdValid;  // Read answer strobe
   } cwd_top_t;

   cwd_top_t    s_r;                 // Registered state
   cwd_top_t    s_nxt;               // Next state
   logic [15:0] storeRd;             // Store read register
   logic [15:0] storedCfg;           // Store copy of word one
   logic        storeWr;             // Store write strobe
   logic        pwrtDone;            // Power-up delay expired
   logic        ostDone;             // Oscillator settle expired
   logic        inRegion;            // Address in config region
   logic        inStore;             // Address held by the store
   logic        access;              // Programming access allowed

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Decode the word; a 0 bit means programmed
   function automatic cwd_pkg::cwd_ctrl_t decode(
      input logic [15:0] w,
      input logic        asleep,
      input logic        softBor,
      input logic        softWdt
   );
      cwd_pkg::cwd_ctrl_t c;
      cwd_pkg::cwd_bor_t  pol;
      c   = '0;
      pol = cwd_pkg::cwd_bor_t'(w[cwd_pkg::BIT_BOR_HI:cwd_pkg::BIT_BOR_LO]);
      c.debugPinsOwned         = ~w[cwd_pkg::BIT_DEBUG];
      c.lowVoltProgEnable      = w[cwd_pkg::BIT_LVP];
      c.clockFailMonitorEnable = w[cwd_pkg::BIT_FCM];
      c.clockSwitchoverEnable  = w[cwd_pkg::BIT_SWO];
      c.dataMemProtect         = ~w[cwd_pkg::BIT_CPD];
      c.programMemProtect      = ~w[cwd_pkg::BIT_CP];
      c.masterClearActive      = w[cwd_pkg::BIT_MASTER_CLEAR_PIN_SELECT];
      c.watchdogEnable = w[cwd_pkg::BIT_WATCHDOG_FORCE_ENABLE] | softWdt;
      case (pol)
         cwd_pkg::BOR_ALWAYS: c.brownoutArmed = 1'b1;
         cwd_pkg::BOR_AWAKE:  c.brownoutArmed = ~asleep;
         cwd_pkg::BOR_SOFT:   c.brownoutArmed = softBor;
         default:             c.brownoutArmed = 1'b0;
      endcase
      return c;
   endfunction : decode

   // ----------------------------------------------------------------
   // Timers and store
   // ----------------------------------------------------------------

   // Power-up delay counts ref_clk cycles
   cwd_delay_timer #(
      .WIDTH (cwd_pkg::POWER_UP_DELAY_TIMER_W),
      .LOAD  (POWER_UP_DELAY_TIMER_CYCLES[cwd_pkg::POWER_UP_DELAY_TIMER_W-1:0])
   ) u_power_up_delay_timer (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .start   (s_r.pwrtStart),
      .tick    (1'b1),
      .done    (pwrtDone)
   );

   // Settle timer counts oscillator ticks, so it tracks the crystal
   cwd_delay_timer #(
      .WIDTH (cwd_pkg::OST_W),
      .LOAD  (cwd_pkg::OSC_SETTLE_TICKS[cwd_pkg::OST_W-1:0])
   ) u_ost (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .start   (s_r.ostStart),
      .tick    (oscTick),
      .done    (ostDone)
   );

   cwd_cfg_store u_store (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .wrEn    (storeWr),
      .idx     (progReq.addr[cwd_pkg::STORE_IDX_W-1:0]),
      .wrData  (progReq.wrData),
      .rdData  (storeRd),
      .cfgWord (storedCfg)
   );

   // ----------------------------------------------------------------
   // Programming access decode
   // ----------------------------------------------------------------

   // Region only open while in programming mode and held in reset
   always_comb begin
      inRegion = (progReq.addr >= cwd_pkg::CFG_SPACE_LO) &&
                 (progReq.addr <= cwd_pkg::CFG_SPACE_HI);
      inStore  = inRegion && (progReq.addr <= cwd_pkg::STORE_TOP);
      access   = s_r.progMode &&
                 (s_r.state == cwd_pkg::ST_HOLD);
      storeWr  = access && progReq.wrEn && inStore;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------

   // One pass computes the whole next state
   always_comb begin
      logic mclrReset;
      logic borReset;
      logic runReset;
      logic lvpPin;
      mclrReset = s_r.ctrl.masterClearActive &
                  ~masterClearPin_b;
      borReset  = s_r.ctrl.brownoutArmed & brownoutDetect;
      runReset  = mclrReset | borReset |
                  (s_r.ctrl.watchdogEnable & wdtTimeout);
      lvpPin    = s_r.ctrl.lowVoltProgEnable & progModePin;
      s_nxt            = s_r;
      s_nxt.pwrtStart  = 1'b0;
      s_nxt.ostStart   = 1'b0;
      s_nxt.wakePulse  = 1'b0;
      s_nxt.rdValid    = 1'b0;
      // Without the pin function only high voltage enters programming
      s_nxt.progMode   = hvProgEntry | lvpPin;
      // Brown-out marks this reset for the long delay
      if (borReset) begin
         s_nxt.needPwrt = 1'b1;
      end
      case (s_r.state)
         cwd_pkg::ST_HOLD: begin
            // Word only follows the store while held
            s_nxt.cfgWord = storedCfg;
            if (!mclrReset && !borReset && !s_nxt.progMode) begin
               s_nxt.needPwrt = 1'b0;
               if (s_r.needPwrt && !storedCfg[cwd_pkg::BIT_POWER_UP_DELAY_ENABLE_N]) begin
                  s_nxt.state     = cwd_pkg::ST_POWER_UP_DELAY_TIMER;
                  s_nxt.pwrtStart = 1'b1;
               end else if (oscCrystalMode) begin
                  s_nxt.state    = cwd_pkg::ST_OST;
                  s_nxt.ostStart = 1'b1;
               end else begin
                  s_nxt.state = cwd_pkg::ST_RUN;
               end
            end
         end
         cwd_pkg::ST_POWER_UP_DELAY_TIMER: begin
            if (runReset) begin
               s_nxt.state = cwd_pkg::ST_HOLD;
            end else if (pwrtDone && !s_r.pwrtStart) begin
               if (oscCrystalMode) begin
                  s_nxt.state    = cwd_pkg::ST_OST;
                  s_nxt.ostStart = 1'b1;
               end else begin
                  s_nxt.state = cwd_pkg::ST_RUN;
               end
            end
         end
         cwd_pkg::ST_OST: begin
            if (runReset) begin
               s_nxt.state = cwd_pkg::ST_HOLD;
            end else if (ostDone && !s_r.ostStart) begin
               s_nxt.state = cwd_pkg::ST_RUN;
            end
         end
         cwd_pkg::ST_RUN: begin
            if (runReset) begin
               s_nxt.state = cwd_pkg::ST_HOLD;
            end else if (sleepReq) begin
               s_nxt.state = cwd_pkg::ST_SLEEP;
            end
         end
         cwd_pkg::ST_SLEEP: begin
            // Watchdog expiry in sleep is a wake, not a reset
            if (mclrReset || borReset) begin
               s_nxt.state     = cwd_pkg::ST_HOLD;
               s_nxt.wakePulse = 1'b1;
            end else if ((s_r.ctrl.watchdogEnable && wdtTimeout) ||
                         irqPending) begin
               s_nxt.wakePulse = 1'b1;
               if (oscCrystalMode) begin
                  s_nxt.state    = cwd_pkg::ST_OST;
                  s_nxt.ostStart = 1'b1;
               end else begin
                  s_nxt.state = cwd_pkg::ST_RUN;
               end
            end
         end
         default: begin
            s_nxt.state = cwd_pkg::ST_HOLD;
         end
      endcase
      s_nxt.sleeping    = (s_nxt.state == cwd_pkg::ST_SLEEP);
      s_nxt.deviceReset = !((s_nxt.state == cwd_pkg::ST_RUN) ||
                            (s_nxt.state == cwd_pkg::ST_SLEEP));
      s_nxt.ctrl = decode(s_nxt.cfgWord, s_nxt.sleeping,
                          softwareBrownoutEnable, watchdogSoftEnable);
      // Reads take two cycles: store register, then answer register
      s_nxt.rdPend = access && progReq.rdEn;
      s_nxt.rdHit  = inStore;
      if (s_r.rdPend) begin
         s_nxt.rdValid = 1'b1;
         s_nxt.rdData  = s_r.rdHit ? storeRd : cwd_pkg::RD_NONE;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------

   // rst_b stands for power-on: erased word, delay owed
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s_r             <= '0;
         s_r.state       <= cwd_pkg::ST_HOLD;
         s_r.cfgWord     <= cwd_pkg::CFG_ERASED;
         s_r.needPwrt    <= 1'b1;
         s_r.deviceReset <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign ctrl           = s_r.ctrl;
   assign deviceReset    = s_r.deviceReset;
   assign sleeping       = s_r.sleeping;
   assign wakePulse      = s_r.wakePulse;
   assign progModeActive = s_r.progMode;
   assign progRdData     = s_r.rdData;
   assign progRdValid    = s_r.rdValid;

endmodule : cwd_config_word_decode

/* File: tb/cwd_monitor.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Port checker for the configuration decoder
// ----------------------------------------------------------------
module cwd_monitor (
   input wire logic                   ref_clk,
   input wire logic                   rst_b,
   input wire logic                   masterClearPin_b,
   input wire logic                   wdtTimeout,
   input wire logic                   irqPending,
   input wire cwd_pkg::cwd_prog_req_t progReq,
   input wire cwd_pkg::cwd_ctrl_t     ctrl,
   input wire logic                   deviceReset,
   input wire logic                   sleeping,
   input wire logic                   wakePulse,
   input wire logic                   progModeActive,
   input wire logic [15:0]            progRdData,
   input wire logic                   progRdValid
);
   // Single domain, so one clock and one disable for all
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   chk_rd_latency: assert property (
      progReq.rdEn && progModeActive && deviceReset |-> ##2 progRdValid)
      else $error("read answer missing");
   chk_rd_refused: assert property (
      progReq.rdEn && !progModeActive |-> ##2 !progRdValid)
      else $error("read answered outside programming");
   chk_unimp_ones: assert property (
      progRdValid |-> progRdData[15:14] == 2'b11 || progRdData == '0)
      else $error("top bits not read as one");
   // Held word only relatches in hold; ctrl still follows sleep and the soft enables
   chk_ctrl_frozen: assert property (
      !deviceReset ##1 !deviceReset |-> $stable(ctrl))
      else $error("controls moved while running");
   chk_irq_wake: assert property (
      sleeping && irqPending |=> wakePulse && !sleeping)
      else $error("interrupt did not wake");
   chk_wake_single: assert property (
      wakePulse |=> !wakePulse)
      else $error("wake pulse too long");
   chk_master_clear_pin_reset: assert property (
      !masterClearPin_b && ctrl.masterClearActive |-> ##[1:2] deviceReset)
      else $error("master clear ignored");
   chk_wdt_reset: assert property (
      wdtTimeout && ctrl.watchdogEnable && !sleeping |-> ##[1:2] deviceReset)
      else $error("watchdog expiry ignored");
   cover property (progRdValid);
   cover property (wakePulse);
   cover property ($fell(deviceReset));
endmodule : cwd_monitor

bind cwd_config_word_decode cwd_monitor cwd_monitor_i (
   .ref_clk, .rst_b, .masterClearPin_b, .wdtTimeout, .irqPending,
   .progReq, .ctrl, .deviceReset, .sleeping, .wakePulse,
   .progModeActive, .progRdData, .progRdValid);

/* File: tb/cwd_prog_model.sv */
`timescale 1ns/1ns
// External programmer: one strobe per request on the programming port
module cwd_prog_model (
   input  wire logic                   ref_clk,
   input  wire logic [15:0]            progRdData,
   input  wire logic                   progRdValid,
   output      logic                   hvProgEntry,
   output      cwd_pkg::cwd_prog_req_t progReq
);
   // High voltage from power-on so entry is seen at the first edge
   initial begin
      hvProgEntry = 1'b1;
      progReq = '0;
   end
   // Strobe lasts one cycle; lines are scrambled, not held, afterwards
   task automatic put(input logic [13:0] a, input logic [15:0] d,
                      input logic w);
      @(posedge ref_clk) #1;
      progReq = '{a, d, w, !w};
      @(posedge ref_clk) #1;
      progReq = '{~a, ~d, 1'b0, 1'b0};
   endtask : put
   // Answer sampled just after the edge that follows the taking edge
   task automatic get(input logic [13:0] a, output logic [15:0] d,
                      output logic v);
      put(a, 16'h0000, 1'b0);
      @(posedge ref_clk);
      #1 d = progRdData;
      v = progRdValid;
   endtask : get
endmodule : cwd_prog_model

/* File: tb/config_word_decode_test.sv */
`timescale 1ns/1ns
module config_word_decode_test;
   localparam int unsigned PW = 20;  // Short delay keeps the run brief
   logic        ref_clk, rst_b, masterClearPin_b, wdtTimeout, irqPending;
   logic        sleepReq, softBor, softWdt, hvProgEntry, deviceReset, bod;
   logic        sleeping, wakePulse, progModeActive, progRdValid, ok;
   logic [15:0] progRdData, rd, w;
   cwd_pkg::cwd_prog_req_t progReq;
   cwd_pkg::cwd_ctrl_t     ctrl;
   int          n_mismatch = 0, check_count = 0, n;
   int unsigned seed = 21243;        // Fixed xorshift start
   logic [15:0] mem [8];             // Behavioural copy of the store
   logic [13:0] adr [5] = '{14'h2000, 14'h2003, 14'h2100, 14'h0007,
                            14'h3FFF}; // Stored, unstored and outside
   cwd_config_word_decode #(.POWER_UP_DELAY_TIMER_CYCLES(PW)) cwd_config_word_decode_i (
      .ref_clk, .rst_b, .masterClearPin_b, .brownoutDetect(bod),
      .wdtTimeout, .irqPending, .sleepReq, .oscCrystalMode(1'b0),
      .oscTick(1'b0), .softwareBrownoutEnable(softBor),
      .watchdogSoftEnable(softWdt), .hvProgEntry, .progModePin(1'b0),
      .progReq, .ctrl, .deviceReset, .sleeping, .wakePulse,
      .progModeActive, .progRdData, .progRdValid);
   cwd_prog_model cwd_prog_model_i (.ref_clk, .progRdData, .progRdValid,
      .hvProgEntry, .progReq);
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Hang guard ends through the normal report
   initial begin
      #200000;
      n_mismatch++;
      results();
   end
   // ------
   // Tasks
   // ------
   task automatic cmp(input string nm, input logic [15:0] e, g);
      check_count++;
      if (e !== g) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task automatic step(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : step
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction : rnd
   // Expected controls; policy 10 counts as armed since not asleep
   function automatic logic [15:0] ctrlExp(input logic [15:0] v);
      logic bor;
      bor = (v[9:8] == 2'b01) ? softBor : v[9];
      return {7'h00, !v[13], v[12], v[11], v[10], bor, !v[7], !v[6],
              v[5], v[3] | softWdt};
   endfunction : ctrlExp
   task automatic wrM(input logic [13:0] a, input logic [15:0] d);
      cwd_prog_model_i.put(a, d, 1'b1);
      if (a >= 14'h2000 && a <= 14'h2007) mem[a[2:0]] = d;
   endtask : wrM
   task automatic rdChk(input logic [13:0] a);
      logic [15:0] e;
      e = (a >= 14'h2000 && a <= 14'h2007) ? mem[a[2:0]] | 16'hC000 : '0;
      cwd_prog_model_i.get(a, rd, ok);
      cmp("rd valid", 16'h0001, {15'h0000, ok});
      cmp("rd data", e, rd);
   endtask : rdChk
   // Bounded wait for the core to be let go
   task automatic runWait();
      n = 0;
      while (deviceReset !== 1'b0 && n < 300) begin
         step(1);
         n++;
      end
      if (n >= 300) begin
         n_mismatch++;
         results();
      end
   endtask : runWait
   initial begin
      {rst_b, wdtTimeout, irqPending, sleepReq, softBor, softWdt, bod} = '0;
      masterClearPin_b = 1'b1;
      foreach (mem[i]) mem[i] = 16'hFFFF;
      step(10);
      rst_b = 1'b1;
      step(3);
      cmp("ctrl", ctrlExp(16'hFFFF), 16'(ctrl));
      cmp("prog mode", 16'h0001, {15'h0000, progModeActive});
      for (int i = 0; i < 10; i++) begin
         w = rnd();
         w[9:8] = i[1:0];    // Every brown-out policy code
         w[4] = 1'b1;        // Delay stays off until the last word
         {softBor, softWdt} = w[1:0];
         wrM(14'h2007, w);
         wrM(adr[i % 5], rnd());
         step(4);
         cmp("ctrl", ctrlExp(w), 16'(ctrl));
         rdChk(14'h2007);
         rdChk(adr[i % 5]);
      end
      {softBor, softWdt} = 2'b00;
      w = 16'hFFEF;          // Delay on, brown-out always, dog forced
      wrM(14'h2007, w);
      step(4);
      cmp("ctrl", ctrlExp(w), 16'(ctrl));
      cwd_prog_model_i.hvProgEntry = 1'b0;
      runWait();
      cmp("delay", 16'h0001, 16'(n >= PW && n <= PW + 8));
      cwd_prog_model_i.get(14'h2007, rd, ok);
      cmp("refused", 16'h0000, {15'h0000, ok});
      for (int i = 0; i < 2; i++) begin
         sleepReq = 1'b1;
         step(1);
         sleepReq = 1'b0;
         step(2);
         cmp("sleep", 16'h0001, {15'h0000, sleeping});
         {wdtTimeout, irqPending} = i ? 2'b01 : 2'b10;
         step(1);
         {wdtTimeout, irqPending} = 2'b00;
         cmp("wake",16'h0004,{wakePulse,sleeping,deviceReset});
         step(2);
      end
      wdtTimeout = 1'b1;
      step(1);
      wdtTimeout = 1'b0;
      cmp("wdt rst", 16'h0001, {15'h0000, deviceReset});
      runWait();
      masterClearPin_b = 1'b0;
      step(2);
      cmp("master_clear_pin", 16'h0001, {15'h0000, deviceReset});
      masterClearPin_b = 1'b1;
      runWait();
      cmp("no delay", 16'h0001, 16'(n < PW));
      bod = 1'b1;
      step(1);
      bod = 1'b0;
      runWait();
      cmp("bor delay", 16'h0001, 16'(n >= PW));
      results();
   end
endmodule : config_word_decode_test
